// >>> rtl/gst_timer.sv
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module gst_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep,
   input wire logic ext_clock_pin,
   input wire logic cap_sense_osc,
   input wire logic crystal_in_pin,
   output logic crystal_out_pin,
   input wire logic gate_input,
   output logic irq
);
   gst_pkg::gst_state_t st_r;
   gst_pkg::gst_state_t st_nxt;

   logic ext_sel;
   logic ext_raw;
   logic ext_rise;
   logic ext_fall;
   logic ext_level;
   logic setup;
   logic wr_acc;
   logic gate_ok;
   logic count_en;
   logic src_tick;
   logic pre_done;
   logic inc;
   logic ovf;
   logic cnt_wr;
   logic [2:0] pre_last;
   logic [31:0] rd_val;
   logic rd_err;

   // ---------------------------------------------------------------
   // external source mux and edge detection
   // ---------------------------------------------------------------
   always_comb begin
      ext_sel = (st_r.src == gst_pkg::GST_SRC_EXT) || (st_r.src == gst_pkg::GST_SRC_CAP);
      if (st_r.src == gst_pkg::GST_SRC_CAP) begin
         ext_raw = cap_sense_osc;
      end else if (st_r.osc_en) begin
         ext_raw = crystal_in_pin;
      end else begin
         ext_raw = ext_clock_pin;
      end
   end

   gst_sync_edge u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .src_in(ext_raw),
      .bypass(st_r.sync_dis),
      .rise(ext_rise),
      .fall(ext_fall),
      .level(ext_level)
   );

   // ---------------------------------------------------------------
   // apb decode and read mux
   // ---------------------------------------------------------------
   always_comb begin
      setup = psel & ~penable;
      wr_acc = psel & penable & pwrite & st_r.pready;
      rd_val = gst_pkg::GST_RDATA_ZERO;
      rd_err = 1'b0;
      case (paddr)
         gst_pkg::GST_OFS_CTRL: begin
            rd_val[gst_pkg::GST_CTRL_RUN] = st_r.run;
            rd_val[gst_pkg::GST_CTRL_SYNC_DIS] = st_r.sync_dis;
            rd_val[gst_pkg::GST_CTRL_OSC_EN] = st_r.osc_en;
            rd_val[gst_pkg::GST_CTRL_RATE_LO +: 2] = st_r.rate;
            rd_val[gst_pkg::GST_CTRL_SRC_LO +: 2] = st_r.src;
         end
         gst_pkg::GST_OFS_GATE: begin
            rd_val[gst_pkg::GST_GATE_EN] = st_r.gate_en;
            rd_val[gst_pkg::GST_GATE_POL] = st_r.gate_pol;
         end
         gst_pkg::GST_OFS_CNT_LO: begin
            rd_val[7:0] = st_r.count[7:0];
         end
         gst_pkg::GST_OFS_CNT_HI: begin
            rd_val[7:0] = st_r.count[15:8];
         end
         gst_pkg::GST_OFS_INT_STAT: begin
            rd_val[gst_pkg::GST_INT_OVF] = st_r.flag;
         end
         gst_pkg::GST_OFS_INT_MASK: begin
            rd_val[gst_pkg::GST_INT_OVF] = st_r.mask;
         end
         gst_pkg::GST_OFS_STATUS: begin
            rd_val[gst_pkg::GST_STAT_OSC] = st_r.osc_en;
            rd_val[gst_pkg::GST_STAT_GATE] = gate_input;
            rd_val[gst_pkg::GST_STAT_ARMED] = st_r.armed;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // count enable, source tick, prescaler
   // ---------------------------------------------------------------
   always_comb begin
      gate_ok = (gate_input == st_r.gate_pol);
      count_en = st_r.run & (~st_r.gate_en | gate_ok);
      case (st_r.src)
         gst_pkg::GST_SRC_SYS: begin
            src_tick = ~sleep;
         end
         gst_pkg::GST_SRC_INSTR: begin
            src_tick = ~sleep & (st_r.div == gst_pkg::GST_INSTR_LAST);
         end
         gst_pkg::GST_SRC_EXT, gst_pkg::GST_SRC_CAP: begin
            // only the unsynchronized path keeps running in sleep
            src_tick = ext_rise & st_r.armed & (~sleep | st_r.sync_dis);
         end
         default: begin
            src_tick = 1'b0;
         end
      endcase
      pre_last = 3'((4'h1 << st_r.rate) - 4'h1);
      pre_done = (st_r.pre == pre_last);
      inc = count_en & src_tick & pre_done;
      ovf = inc & (st_r.count == gst_pkg::GST_COUNT_MAX);
      cnt_wr = wr_acc & ((paddr == gst_pkg::GST_OFS_CNT_LO) || (paddr == gst_pkg::GST_OFS_CNT_HI));
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;

      // bus answer: one wait-free access phase after setup
      st_nxt.pready = setup & ~st_r.pready;
      st_nxt.pslverr = setup & ~st_r.pready & rd_err;
      if (setup & ~st_r.pready) begin
         st_nxt.prdata = pwrite ? gst_pkg::GST_RDATA_ZERO : rd_val;
      end

      // instruction clock divider, every fourth system clock
      st_nxt.div = 2'(st_r.div + 2'h1);

      // prescaler and counter
      if (count_en & src_tick) begin
         st_nxt.pre = pre_done ? 3'h0 : 3'(st_r.pre + 3'h1);
      end
      if (inc) begin
         st_nxt.count = 16'(st_r.count + 16'h1);
      end

      // falling-edge arming for counter mode
      if (ext_sel & ext_fall) begin
         st_nxt.armed = 1'b1;
      end
      if (~st_r.run) begin
         st_nxt.armed = 1'b0;
      end

      // register writes
      if (wr_acc) begin
         case (paddr)
            gst_pkg::GST_OFS_CTRL: begin
               st_nxt.run = pwdata[gst_pkg::GST_CTRL_RUN];
               st_nxt.sync_dis = pwdata[gst_pkg::GST_CTRL_SYNC_DIS];
               st_nxt.osc_en = pwdata[gst_pkg::GST_CTRL_OSC_EN];
               st_nxt.rate = pwdata[gst_pkg::GST_CTRL_RATE_LO +: 2];
               st_nxt.src = pwdata[gst_pkg::GST_CTRL_SRC_LO +: 2];
            end
            gst_pkg::GST_OFS_GATE: begin
               st_nxt.gate_en = pwdata[gst_pkg::GST_GATE_EN];
               st_nxt.gate_pol = pwdata[gst_pkg::GST_GATE_POL];
            end
            gst_pkg::GST_OFS_CNT_LO: begin
               st_nxt.count[7:0] = pwdata[7:0];
            end
            gst_pkg::GST_OFS_CNT_HI: begin
               st_nxt.count[15:8] = pwdata[7:0];
            end
            gst_pkg::GST_OFS_INT_STAT: begin
               if (pwdata[gst_pkg::GST_INT_OVF]) begin
                  st_nxt.flag = 1'b0;
               end
            end
            gst_pkg::GST_OFS_INT_MASK: begin
               st_nxt.mask = pwdata[gst_pkg::GST_INT_OVF];
            end
            default: begin
               st_nxt.mask = st_r.mask;
            end
         endcase
      end

      // a count write clears the prescaler and disarms the edge gate
      if (cnt_wr) begin
         st_nxt.pre = 3'h0;
         st_nxt.armed = 1'b0;
      end

      // overflow sets the flag unless a count write lands in the same cycle; set wins over a clear in the same cycle
      if (ovf & ~cnt_wr) begin
         st_nxt.flag = 1'b1;
      end

      // level interrupt, also serves as wake request in sleep
      st_nxt.irq = st_nxt.flag & st_nxt.mask;

      // crystal amplifier output, active only while enabled
      st_nxt.xtal_out = st_nxt.osc_en & ~crystal_in_pin;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.count <= gst_pkg::GST_COUNT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign irq = st_r.irq;
   assign crystal_out_pin = st_r.xtal_out;

endmodule : gst_timer

// >>> rtl/gst_pkg.sv
package gst_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] GST_OFS_CTRL = 8'h00;
   localparam logic [7:0] GST_OFS_GATE = 8'h04;
   localparam logic [7:0] GST_OFS_CNT_LO = 8'h08;
   localparam logic [7:0] GST_OFS_CNT_HI = 8'h0c;
   localparam logic [7:0] GST_OFS_INT_STAT = 8'h10;
   localparam logic [7:0] GST_OFS_INT_MASK = 8'h14;
   localparam logic [7:0] GST_OFS_STATUS = 8'h18;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int GST_CTRL_RUN = 0;
   localparam int GST_CTRL_SYNC_DIS = 2;
   localparam int GST_CTRL_OSC_EN = 3;
   localparam int GST_CTRL_RATE_LO = 4;
   localparam int GST_CTRL_SRC_LO = 6;
   localparam int GST_GATE_POL = 6;
   localparam int GST_GATE_EN = 7;
   localparam int GST_INT_OVF = 0;
   localparam int GST_STAT_OSC = 0;
   localparam int GST_STAT_GATE = 1;
   localparam int GST_STAT_ARMED = 2;

   // ---------------------------------------------------------------
   // encodings, reset values, counts
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      GST_SRC_INSTR = 2'b00,
      GST_SRC_SYS = 2'b01,
      GST_SRC_EXT = 2'b10,
      GST_SRC_CAP = 2'b11
   } gst_src_t;

   localparam logic [15:0] GST_COUNT_MAX = 16'hffff;
   localparam logic [15:0] GST_COUNT_RST = 16'h0000;
   localparam logic [1:0] GST_INSTR_LAST = 2'h3;
   localparam logic [31:0] GST_RDATA_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic run;
      logic sync_dis;
      logic osc_en;
      logic [1:0] rate;
      logic [1:0] src;
      logic gate_en;
      logic gate_pol;
      logic [15:0] count;
      logic [2:0] pre;
      logic [1:0] div;
      logic armed;
      logic flag;
      logic mask;
      logic irq;
      logic xtal_out;
   } gst_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } gst_edge_state_t;

endpackage : gst_pkg

// >>> rtl/gst_sync_edge.sv
`timescale 1ns/1ps
// two-stage synchronizer with bypass, plus edge detection
module gst_sync_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic src_in,
   input wire logic bypass,
   output logic rise,
   output logic fall,
   output logic level
);
   gst_pkg::gst_edge_state_t st_r;
   gst_pkg::gst_edge_state_t st_nxt;
   logic lvl;

   // ---------------------------------------------------------------
   // level select and edges
   // ---------------------------------------------------------------
   always_comb begin
      lvl = bypass ? src_in : st_r.s2;
      st_nxt = st_r;
      st_nxt.s1 = src_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.prev = lvl;
      rise = lvl & ~st_r.prev;
      fall = ~lvl & st_r.prev;
      level = lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : gst_sync_edge

// >>> testbench/gst_timer_assertions.sv
`timescale 1ns/1ps
module gst_timer_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic crystal_in_pin,
   input wire logic crystal_out_pin,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_setup_ready: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
      else $error("no error on unmapped");
   a_ok_mapped: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped");
   a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_cnt_upper: assert property (pready && !pwrite && paddr[7:3] == 5'h01 |-> prdata[31:8] == 24'h00_0000)
      else $error("count byte upper bits");
   a_xtal_follow: assert property (crystal_out_pin |-> !$past(crystal_in_pin))
      else $error("crystal amp not inverting");
   a_irq_masked: assert property (pready && pwrite && paddr == gst_pkg::GST_OFS_INT_MASK && !pwdata[0]
      |=> ##1 !irq)
      else $error("irq while masked");
endmodule : gst_timer_assertions

// >>> testbench/gst_ext_model.sv
`timescale 1ns/1ps
module gst_ext_model (
   input wire logic pclk,
   input wire logic [1:0] sel,
   output logic ext_clock_pin,
   output logic cap_sense_osc,
   output logic crystal_in_pin
);
   logic wave;
   initial wave = 1'b0;
   // only the chosen source moves, the others stand still low
   always_comb begin
      ext_clock_pin = wave & (sel == 2'h0);
      cap_sense_osc = wave & (sel == 2'h1);
      crystal_in_pin = wave & (sel == 2'h2);
   end
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge pclk);
         wave <= 1'b1;
         repeat (4) @(posedge pclk);
         wave <= 1'b0;
      end
   endtask : pulses
endmodule : gst_ext_model

// >>> testbench/tb_gst_timer.sv
`timescale 1ns/1ps
module tb_gst_timer;
   logic pclk, presetn, psel, penable, pwrite, sleep, gate_input, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, crystal_out_pin, irq, ext_clock_pin, cap_sense_osc, crystal_in_pin;
   logic [1:0] sel;
   int fail_count, n_compared;
   gst_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep(sleep), .ext_clock_pin(ext_clock_pin),
      .cap_sense_osc(cap_sense_osc), .crystal_in_pin(crystal_in_pin),
      .crystal_out_pin(crystal_out_pin), .gate_input(gate_input), .irq(irq));
   gst_ext_model u_src (.pclk(pclk), .sel(sel), .ext_clock_pin(ext_clock_pin),
      .cap_sense_osc(cap_sense_osc), .crystal_in_pin(crystal_in_pin));
   always #5 pclk = ~pclk;
   // ---------------------------------------------------------------
   // bus and compare helpers
   // ---------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(name, exp, rd);
   endtask : rdchk
   task automatic clr_count(input logic [7:0] c);
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h0);
      xfer(1'b1, gst_pkg::GST_OFS_CNT_LO, {24'h0, c});
      xfer(1'b1, gst_pkg::GST_OFS_CNT_HI, {24'h0, c});
   endtask : clr_count
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rdchk("ctrl", gst_pkg::GST_OFS_CTRL, 32'h0);
      rdchk("cnt_lo", gst_pkg::GST_OFS_CNT_LO, 32'h0);
      rdchk("unmapped", 8'h1c, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
   endtask : t_reset
   task automatic t_ext;
      logic [7:0] ctl [3] = '{8'h81, 8'hc1, 8'h89};
      for (int k = 0; k < 3; k++) begin
         clr_count(8'h00);
         xfer(1'b1, gst_pkg::GST_OFS_CTRL, {24'h0, ctl[k] & 8'hfe});
         repeat (20) @(posedge pclk);
         xfer(1'b1, gst_pkg::GST_OFS_CTRL, {24'h0, ctl[k]});
         sel <= k[1:0];
         u_src.pulses(5);
         repeat (8) @(posedge pclk);
         rdchk("ext_count", gst_pkg::GST_OFS_CNT_LO, 32'h4);
         rdchk("ext_status", gst_pkg::GST_OFS_STATUS, (k == 2) ? 32'h5 : 32'h4);
         sel <= 2'h3;
      end
   endtask : t_ext
   task automatic t_async;
      clr_count(8'h00);
      sleep <= 1'b1;
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h95);
      sel <= 2'h0;
      u_src.pulses(7);
      repeat (8) @(posedge pclk);
      sleep <= 1'b0;
      rdchk("async_prescaled", gst_pkg::GST_OFS_CNT_LO, 32'h3);
      sel <= 2'h3;
   endtask : t_async
   task automatic t_gate;
      clr_count(8'h00);
      gate_input <= 1'b0;
      xfer(1'b1, gst_pkg::GST_OFS_GATE, 32'hc0);
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h41);
      repeat (20) @(posedge pclk);
      rdchk("gate_hold", gst_pkg::GST_OFS_CNT_LO, 32'h0);
      xfer(1'b1, gst_pkg::GST_OFS_GATE, 32'h80);
      repeat (10) @(posedge pclk);
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h0);
      rdchk("gate_low", gst_pkg::GST_OFS_CNT_HI, 32'h0);
      rdchk("gate_low_ran", gst_pkg::GST_OFS_CNT_LO, 32'hd);
      repeat (10) @(posedge pclk);
      rdchk("off_hold", gst_pkg::GST_OFS_CNT_LO, rd);
      xfer(1'b1, gst_pkg::GST_OFS_GATE, 32'h0);
   endtask : t_gate
   task automatic t_ovf;
      clr_count(8'hff);
      xfer(1'b1, gst_pkg::GST_OFS_INT_MASK, 32'h1);
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h41);
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h0);
      chk("irq_set", 32'h1, {31'h0, irq});
      rdchk("ovf_flag", gst_pkg::GST_OFS_INT_STAT, 32'h1);
      rdchk("wrapped_hi", gst_pkg::GST_OFS_CNT_HI, 32'h0);
      xfer(1'b1, gst_pkg::GST_OFS_INT_STAT, 32'h1);
      repeat (3) @(posedge pclk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      xfer(1'b1, gst_pkg::GST_OFS_INT_MASK, 32'h0);
   endtask : t_ovf
   task automatic t_instr;
      clr_count(8'h00);
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h11);
      repeat (37) @(posedge pclk);
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h0);
      rdchk("instr_count", gst_pkg::GST_OFS_CNT_LO, 32'h5);
   endtask : t_instr
   task automatic t_midreset;
      xfer(1'b1, gst_pkg::GST_OFS_CTRL, 32'h41);
      repeat (4) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("reset_ctrl", gst_pkg::GST_OFS_CTRL, 32'h0);
      rdchk("reset_cnt", gst_pkg::GST_OFS_CNT_LO, 32'h0);
   endtask : t_midreset
   task automatic complete_run;
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      #200us;
      fail_count++;
      complete_run();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, sleep, gate_input} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sel = 2'h3;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ext();
      t_async();
      t_gate();
      t_ovf();
      t_instr();
      t_midreset();
      complete_run();
   end
endmodule : tb_gst_timer
bind gst_timer gst_timer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .crystal_in_pin(crystal_in_pin),
   .crystal_out_pin(crystal_out_pin), .irq(irq));
